// *** hw/link_pkg.sv ***
// shared constants for the negotiation and 10BASE-T link register bank
// assumes a single 10 MHz clock domain
package link_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  // negotiation and link test timers in ticks of TICK_US; link pass count in pulses
  localparam int BREAK_MS = 1200 / TICK_US * 1000 / 1000;
  localparam logic [7:0] BREAK_TICKS = 8'h04;
  localparam logic [7:0] COMPLETE_TICKS = 8'h02;
  localparam logic [7:0] LINK_CHECK_TICKS = 8'h32;
  localparam logic [7:0] LINK_LOSS_TICKS = 8'h64;
  localparam logic [1:0] PASS_PULSES = 2'h2;
  // register byte addresses
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] RESET_OFS = 4'h4;
  localparam logic [3:0] CONTROL_OFS = 4'h8;
  // status fields
  localparam int WORD_LSB = 16;
  localparam int NEGOTIABLE_BIT = 15;
  localparam int STATE_LSB = 12;
  localparam int REMOTE_FAULT_BIT = 11;
  localparam int POLARITY_BIT = 3;
  localparam int TEN_FAIL_BIT = 2;
  localparam int HUNDRED_FAIL_BIT = 1;
  // reset register fields
  localparam int NEG_RESET_BIT = 0;
  localparam int PHY_RESET_BIT = 1;
  // control fields
  localparam int ADV_PAUSE_BIT = 19;
  localparam int ADV_T4_BIT = 18;
  localparam int ADV_FAST_FULL_BIT = 17;
  localparam int ADV_FAST_HALF_BIT = 16;
  localparam int LINK_TEST_BIT = 12;
  localparam int SQUELCH_BIT = 8;
  localparam int NEG_EN_BIT = 7;
  localparam int ADV_TEN_HALF_BIT = 6;
  localparam int POWER_ON_BIT = 2;
  localparam int LOOPBACK_BIT = 1;
  localparam logic [31:0] CONTROL_RESET = 32'h000f_11c4;
  localparam logic [31:0] RESET_REG_RESET = 32'h0000_0001;
  localparam logic [31:0] CONTROL_MASK = 32'h000f_11c6;
  localparam logic [31:0] RESET_MASK = 32'h0000_0003;
  localparam logic [4:0] SELECTOR = 5'h01;
  localparam int ACK_BIT = 14;
  typedef enum logic [2:0] {
    ARB_DISABLED = 3'b000,
    ARB_TX_DISABLE = 3'b001,
    ARB_ABILITY = 3'b010,
    ARB_ACK = 3'b011,
    ARB_COMPLETE_ACK = 3'b100,
    ARB_LINK_GOOD = 3'b101,
    ARB_LINK_CHECK = 3'b110
  } arb_state_type;
endpackage

// *** hw/negotiation_arbiter.sv ***
// arbitration state machine for link code word exchange
// assumes partner words arrive decoded, one-cycle valid, and a ms tick
module negotiation_arbiter
  import link_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic enable,
  input wire logic restart,
  input wire logic tick,
  // partner side
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  input wire logic link_ready,
  // results
  output arb_state_type state,
  output logic [15:0] partner_word,
  output logic partner_seen,
  output logic complete
);
  arb_state_type state_reg, state_next;
  logic [7:0] timer_reg;
  logic timer_done;

  assign state = state_reg;
  assign timer_done = tick && timer_reg == 8'h00;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ARB_DISABLED: if (enable) state_next = ARB_TX_DISABLE;
      ARB_TX_DISABLE: if (timer_done) state_next = ARB_ABILITY;
      ARB_ABILITY: if (word_valid) state_next = ARB_ACK;
      ARB_ACK: if (word_valid && word_in[ACK_BIT]) state_next = ARB_COMPLETE_ACK;
      ARB_COMPLETE_ACK: if (timer_done) state_next = ARB_LINK_CHECK;
      ARB_LINK_CHECK: begin
        if (link_ready) state_next = ARB_LINK_GOOD;
        else if (timer_done) state_next = ARB_TX_DISABLE;
      end
      ARB_LINK_GOOD: if (!link_ready) state_next = ARB_TX_DISABLE;
      default: state_next = ARB_DISABLED;
    endcase
    if (restart && enable) state_next = ARB_TX_DISABLE;
    if (!enable) state_next = ARB_DISABLED;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_reg <= ARB_DISABLED;
    else state_reg <= state_next;
  end

  // per-state timer reloads on every state change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) timer_reg <= BREAK_TICKS;
    else if (state_next != state_reg || (restart && enable)) begin
      unique case (state_next)
        ARB_COMPLETE_ACK: timer_reg <= COMPLETE_TICKS;
        ARB_LINK_CHECK: timer_reg <= LINK_CHECK_TICKS;
        default: timer_reg <= BREAK_TICKS;
      endcase
    end else if (tick && timer_reg != 8'h00) timer_reg <= timer_reg - 8'h01;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      partner_word <= 16'h0000;
      partner_seen <= 1'b0;
    end else if (state_next == ARB_DISABLED || state_next == ARB_TX_DISABLE) begin
      partner_seen <= 1'b0;
    end else if (word_valid && (state_reg == ARB_ABILITY || state_reg == ARB_ACK)) begin
      partner_word <= word_in;
      partner_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) complete <= 1'b0;
    else complete <= state_next == ARB_LINK_GOOD && state_reg != ARB_LINK_GOOD;
  end
endmodule

// *** hw/ten_link_monitor.sv ***
// 10BASE-T link test and polarity tracking, plus the ms tick divider
// assumes link pulses arrive as one-cycle strobes with their sensed polarity
module ten_link_monitor
  import link_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic test_en,
  input wire logic clear,
  // line
  input wire logic pulse,
  input wire logic pulse_positive,
  // results
  output logic tick,
  output logic link_fail,
  output logic polarity_positive
);
  logic [$clog2(TICK_DIV)-1:0] div_reg;
  logic [7:0] idle_reg;
  logic [1:0] good_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= div_reg == '0;
      div_reg <= div_reg == '0 ? ($clog2(TICK_DIV))'(TICK_DIV - 1) : div_reg - 1'b1;
    end
  end

  // fail after a quiet spell, pass again after a few pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_reg <= 8'h00;
      good_reg <= 2'h0;
      link_fail <= 1'b1;
    end else if (clear || !test_en) begin
      idle_reg <= 8'h00;
      good_reg <= 2'h0;
      link_fail <= test_en;
    end else if (pulse) begin
      idle_reg <= 8'h00;
      if (good_reg == PASS_PULSES - 2'h1) link_fail <= 1'b0;
      else good_reg <= good_reg + 2'h1;
    end else if (tick) begin
      if (idle_reg == LINK_LOSS_TICKS) begin
        link_fail <= 1'b1;
        good_reg <= 2'h0;
      end else idle_reg <= idle_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) polarity_positive <= 1'b1;
    else if (clear) polarity_positive <= 1'b1;
    else if (pulse) polarity_positive <= pulse_positive;
  end
endmodule

// *** hw/autoneg_link_status_control.sv ***
// status, reset and control registers for negotiation and the 10BASE-T port
// assumes an Avalon-MM master on clk; software reset of the controller is
// brought in only so that it can be ignored here
//
// Contract
// - status top half holds partner code word
// - bit 15 set when partner negotiates and enabled
// - state field uses the seven listed codes
// - completion raises interrupt status bit 4; here it only pulses negotiation_complete_irq for one cycle
// - writing 001 restarts negotiation when enabled
// - bit 3 polarity; negative inverts received stream
// - bit 2 set while 10BASE-T link fails
// - bit 1 shows signal detect low as fail
// - software reset leaves status and control alone
// - writing 0 to reset bit 0 clears registers
// - writing 1 to reset bit 1 resets PHY
// - control 19..16 give code word bits 10..7
// - control bit 6 gives code word bit 5
// - control bit 12 enables link test
// - control bit 8 enables receive squelch
// - control bit 2 clear powers port down
// - control bit 1 enables 10BASE-T loopback
module autoneg_link_status_control
  import link_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // controller context
  input wire logic soft_reset,
  input wire logic pcs_mode,
  output logic negotiation_complete_irq,
  output logic phy_reset,
  // partner and line
  input wire logic partner_word_valid,
  input wire logic [15:0] partner_word_in,
  input wire logic link_ready,
  input wire logic remote_fault_tx,
  input wire logic signal_detect,
  input wire logic link_pulse,
  input wire logic link_pulse_positive,
  output logic [15:0] adv_code_word,
  // 10BASE-T port controls
  output logic ten_port_oe,
  output logic rx_invert,
  output logic link_test_en,
  output logic rx_squelch_en,
  output logic ten_loopback_en
);
  logic ack_reg;
  logic take;
  logic wr_take;
  logic [31:0] mask;
  logic [31:0] control_reg;
  logic [31:0] reset_reg;
  logic [31:0] status_word;
  logic neg_clear;
  logic restart;
  logic negotiation_en;
  logic tick;
  logic ten_link_fail;
  logic hundred_link_fail;
  logic polarity_state;
  logic partner_seen;
  logic partner_negotiable;
  logic [15:0] partner_code_word;
  arb_state_type arbitration_state;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // one wait cycle per access; read data is ready when waitrequest drops
  assign take = (read || write) && !ack_reg;
  assign waitrequest = (read || write) && !ack_reg;
  assign wr_take = write && ack_reg;
  assign mask = lane_mask(byteenable);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ack_reg <= 1'b0;
    else ack_reg <= take;
  end

  // a zero in bit 0 of the reset register clears both ports
  assign neg_clear = wr_take && address == RESET_OFS && byteenable[0] && !writedata[NEG_RESET_BIT];
  assign restart = wr_take && address == STATUS_OFS && byteenable[1]
    && writedata[STATE_LSB +: 3] == ARB_TX_DISABLE;

  // soft_reset is deliberately not a term here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) control_reg <= CONTROL_RESET;
    else if (neg_clear) control_reg <= CONTROL_RESET;
    else if (wr_take && address == CONTROL_OFS)
      control_reg <= (control_reg & ~mask) | (writedata & mask & CONTROL_MASK);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reset_reg <= RESET_REG_RESET;
    else if (wr_take && address == RESET_OFS)
      reset_reg <= (reset_reg & ~mask) | (writedata & mask & RESET_MASK);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) phy_reset <= 1'b0;
    else phy_reset <= wr_take && address == RESET_OFS && byteenable[0] && writedata[PHY_RESET_BIT];
  end

  assign negotiation_en = control_reg[NEG_EN_BIT];
  assign link_test_en = control_reg[LINK_TEST_BIT];
  assign rx_squelch_en = control_reg[SQUELCH_BIT];
  assign ten_port_oe = control_reg[POWER_ON_BIT];
  assign ten_loopback_en = control_reg[LOOPBACK_BIT];
  assign rx_invert = !polarity_state;
  assign hundred_link_fail = !signal_detect;
  assign partner_negotiable = partner_seen && negotiation_en;

  // advertised word only means something with negotiation on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) adv_code_word <= 16'h0000;
    else begin
      adv_code_word <= 16'h0000;
      adv_code_word[4:0] <= SELECTOR;
      adv_code_word[5] <= control_reg[ADV_TEN_HALF_BIT];
      adv_code_word[10:7] <= control_reg[ADV_PAUSE_BIT:ADV_FAST_HALF_BIT];
      adv_code_word[ACK_BIT] <= arbitration_state == ARB_ACK || arbitration_state == ARB_COMPLETE_ACK;
    end
  end

  negotiation_arbiter arbiter (
    .clk(clk),
    .rstn(rstn),
    .enable(negotiation_en && !neg_clear),
    .restart(restart),
    .tick(tick),
    .word_valid(partner_word_valid),
    .word_in(partner_word_in),
    .link_ready(link_ready),
    .state(arbitration_state),
    .partner_word(partner_code_word),
    .partner_seen(partner_seen),
    .complete(negotiation_complete_irq)
  );

  ten_link_monitor #(
    .TICK_DIV(TICK_DIV)
  ) monitor (
    .clk(clk),
    .rstn(rstn),
    .test_en(link_test_en),
    .clear(neg_clear),
    .pulse(link_pulse),
    .pulse_positive(link_pulse_positive),
    .tick(tick),
    .link_fail(ten_link_fail),
    .polarity_positive(polarity_state)
  );

  // the state field is live; other writable looking bits are read only
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[WORD_LSB +: 16] = partner_code_word;
    status_word[NEGOTIABLE_BIT] = partner_negotiable;
    status_word[STATE_LSB +: 3] = arbitration_state;
    status_word[REMOTE_FAULT_BIT] = remote_fault_tx;
    status_word[POLARITY_BIT] = polarity_state;
    status_word[TEN_FAIL_BIT] = ten_link_fail;
    status_word[HUNDRED_FAIL_BIT] = hundred_link_fail;
  end

  // unmapped addresses read as zero and drop writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) readdata <= 32'h0000_0000;
    else if (take && read) begin
      unique case (address)
        STATUS_OFS: readdata <= status_word;
        RESET_OFS: readdata <= reset_reg;
        CONTROL_OFS: readdata <= control_reg;
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  sequence s_write_reg(logic [3:0] ofs);
    wr_take && address == ofs && byteenable[0];
  endsequence

  a_bus_one_wait: assert property (@(posedge clk) disable iff (!rstn)
    $rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("access not answered after one wait cycle");

  a_restart_arbiter: assert property (@(posedge clk) disable iff (!rstn)
    restart && negotiation_en && !neg_clear |=> arbitration_state == ARB_TX_DISABLE)
    else $error("restart did not enter transmit disable");

  a_disabled_state: assert property (@(posedge clk) disable iff (!rstn)
    !negotiation_en ##1 !negotiation_en |-> arbitration_state == ARB_DISABLED)
    else $error("state field not zero while negotiation off");

  a_complete_good: assert property (@(posedge clk) disable iff (!rstn)
    negotiation_complete_irq |-> arbitration_state == ARB_LINK_GOOD && $past(arbitration_state) != ARB_LINK_GOOD)
    else $error("completion pulse without entering link good");

  a_neg_clear: assert property (@(posedge clk) disable iff (!rstn)
    s_write_reg(RESET_OFS) and !writedata[NEG_RESET_BIT] |=> control_reg == CONTROL_RESET)
    else $error("control not cleared by reset register");

  a_phy_reset_pulse: assert property (@(posedge clk) disable iff (!rstn)
    s_write_reg(RESET_OFS) and writedata[PHY_RESET_BIT] |=> phy_reset ##1 !phy_reset)
    else $error("phy reset not one pulse after write");

  a_soft_reset_kept: assert property (@(posedge clk) disable iff (!rstn)
    soft_reset && !wr_take |=> $stable(control_reg))
    else $error("software reset disturbed control");

  a_fail_bits: assert property (@(posedge clk) disable iff (!rstn)
    status_word[HUNDRED_FAIL_BIT] == !signal_detect && status_word[POLARITY_BIT] == !rx_invert)
    else $error("fail or polarity bits wrong");

  a_link_test_off: assert property (@(posedge clk) disable iff (!rstn)
    !link_test_en ##1 !link_test_en |-> !ten_link_fail)
    else $error("link fail shown with link test off");

  a_adv_word: assert property (@(posedge clk) disable iff (!rstn)
    $stable(control_reg) |=> adv_code_word[10:7] == $past(control_reg[ADV_PAUSE_BIT:ADV_FAST_HALF_BIT])
      && adv_code_word[5] == $past(control_reg[ADV_TEN_HALF_BIT]))
    else $error("advertised bits do not follow control");
endmodule

// *** bench/link_partner_model.sv ***
// remote link partner: code words, link pulses and line levels
// assumes the bank's clk; every change lands just after a rising edge
module link_partner_model (
  // clock
  input wire logic clk,
  // towards the bank
  output logic word_valid,
  output logic [15:0] word,
  output logic pulse,
  output logic pulse_pos,
  output logic link_ready,
  output logic sig_det,
  output logic fault
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    word_valid = 1'b0;
    word = 16'h0000;
    pulse = 1'b0;
    pulse_pos = 1'b0;
    link_ready = 1'b0;
    sig_det = 1'b1;
    fault = 1'b0;
  end

  // idle word is the inverse of the last one, so stale data never looks valid
  task automatic send_word(input logic [15:0] w);
    @(posedge clk);
    word_valid <= 1'b1;
    word <= w;
    @(posedge clk);
    word_valid <= 1'b0;
    word <= ~w;
  endtask

  task automatic pulses(input int n, input logic pos);
    repeat (n) begin
      @(posedge clk);
      pulse <= 1'b1;
      pulse_pos <= pos;
      @(posedge clk);
      pulse <= 1'b0;
      pulse_pos <= ~pos;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic line(input logic lr, input logic det, input logic rf);
    @(posedge clk);
    link_ready <= lr;
    sig_det <= det;
    fault <= rf;
  endtask
endmodule

// *** bench/autoneg_link_status_control_tb.sv ***
// self-checking bench for the negotiation and 10BASE-T register bank
// assumes the bank answers Avalon-MM with waitrequest; tick divider shortened to 4
module autoneg_link_status_control_tb import link_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic soft_reset = 1'b0;
  logic irq, phy_reset, pwv, pulse, ppos, lready, sdet, rfault;
  logic [15:0] pword, adv_code_word;
  logic ten_port_oe, rx_invert, link_test_en, rx_squelch_en, ten_loopback_en;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int irq_n = 0;
  int phy_n = 0;

  always #50 clk = ~clk;

  autoneg_link_status_control #(.TICK_DIV(4)) dut (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .soft_reset(soft_reset), .pcs_mode(1'b1),
    .negotiation_complete_irq(irq), .phy_reset(phy_reset),
    .partner_word_valid(pwv), .partner_word_in(pword), .link_ready(lready),
    .remote_fault_tx(rfault), .signal_detect(sdet), .link_pulse(pulse),
    .link_pulse_positive(ppos), .adv_code_word(adv_code_word),
    .ten_port_oe(ten_port_oe), .rx_invert(rx_invert), .link_test_en(link_test_en),
    .rx_squelch_en(rx_squelch_en), .ten_loopback_en(ten_loopback_en)
  );

  link_partner_model partner (
    .clk(clk), .word_valid(pwv), .word(pword), .pulse(pulse), .pulse_pos(ppos),
    .link_ready(lready), .sig_det(sdet), .fault(rfault)
  );

  // pulses are one cycle wide, so each edge with the flag high is one event
  always @(posedge clk) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (phy_reset === 1'b1) phy_n++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic results;
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chk("wait edges", 32'd2, n);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic poll(input string name, input logic [31:0] mask, input logic [31:0] val);
    logic [31:0] q;
    int i;
    i = 0;
    do begin
      rd(STATUS_OFS, q);
      i++;
    end while ((q & mask) !== val && i < 300);
    chk(name, val, q & mask);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    rd(CONTROL_OFS, q);
    chk("control", 32'h000f_11c4, q);
    rd(RESET_OFS, q);
    chk("reset reg", 32'h0000_0001, q);
    rd(4'hc, q);
    chk("unmapped", 32'h0, q);
    wr(4'hc, 32'hffff_ffff);
    rd(CONTROL_OFS, q);
    chk("control", 32'h000f_11c4, q);
    chk("oe", 32'h1, ten_port_oe);
    chk("squelch", 32'h1, rx_squelch_en);
    chk("loopback", 32'h0, ten_loopback_en);
    chk("adv word", 32'h07a1, adv_code_word);
  endtask

  task automatic t_neg;
    logic [31:0] q;
    irq_n = 0;
    wr(STATUS_OFS, 32'h0000_1000);
    poll("state", 32'h7000, 32'h1000);
    poll("state", 32'h7000, 32'h2000);
    partner.send_word(16'h05e1);
    poll("state", 32'h7000, 32'h3000);
    partner.send_word(16'h45e1);
    poll("state", 32'h7000, 32'h4000);
    poll("state", 32'h7000, 32'h6000);
    partner.line(1'b1, 1'b1, 1'b0);
    poll("state", 32'h7000, 32'h5000);
    rd(STATUS_OFS, q);
    chk("partner word", 32'h45e1, q[31:16]);
    chk("negotiable", 32'h1, q[15]);
    chk("irq count", 32'h1, irq_n);
    partner.line(1'b0, 1'b1, 1'b0);
    poll("state", 32'h7000, 32'h1000);
  endtask

  task automatic t_line;
    logic [31:0] q;
    for (int i = 0; i < 2; i++) begin
      partner.line(1'b0, i[0], i[0]);
      rd(STATUS_OFS, q);
      chk("fault", i, q[11]);
      chk("detect fail", !i[0], q[1]);
    end
  endtask

  task automatic t_ltest;
    logic [31:0] q;
    partner.pulses(2, 1'b0);
    rd(STATUS_OFS, q);
    chk("ten fail", 32'h0, q[2]);
    chk("polarity", 32'h0, q[3]);
    chk("invert", 32'h1, rx_invert);
    partner.pulses(2, 1'b1);
    rd(STATUS_OFS, q);
    chk("polarity", 32'h1, q[3]);
    chk("invert", 32'h0, rx_invert);
    poll("ten fail", 32'h4, 32'h4);
    wr(CONTROL_OFS, 32'h000f_01c4);
    rd(STATUS_OFS, q);
    chk("ten fail", 32'h0, q[2]);
    chk("link test", 32'h0, link_test_en);
  endtask

  task automatic t_ctrl;
    logic [31:0] q;
    wr(CONTROL_OFS, 32'hfffa_3f02);
    rd(CONTROL_OFS, q);
    chk("control", 32'h000a_1102, q);
    chk("oe", 32'h0, ten_port_oe);
    chk("link test", 32'h1, link_test_en);
    chk("squelch", 32'h1, rx_squelch_en);
    chk("loopback", 32'h1, ten_loopback_en);
    chk("adv word", 32'h0501, adv_code_word);
    wr(STATUS_OFS, 32'h0000_1000);
    rd(STATUS_OFS, q);
    chk("neg bits", 32'h0, q[15:12]);
  endtask

  task automatic t_rst;
    logic [31:0] q;
    phy_n = 0;
    wr(RESET_OFS, 32'h0000_0002);
    rd(CONTROL_OFS, q);
    chk("control", 32'h000f_11c4, q);
    rd(RESET_OFS, q);
    chk("reset reg", 32'h0000_0002, q);
    wr(RESET_OFS, 32'h0000_0001);
    rd(RESET_OFS, q);
    chk("phy resets", 32'h1, phy_n);
  endtask

  task automatic t_soft;
    logic [31:0] q;
    wr(CONTROL_OFS, 32'h0000_1186);
    soft_reset <= 1'b1;
    repeat (3) @(posedge clk);
    soft_reset <= 1'b0;
    rd(CONTROL_OFS, q);
    chk("control", 32'h0000_1186, q);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_neg();
    t_line();
    t_ltest();
    t_ctrl();
    t_rst();
    t_soft();
    results();
  end
endmodule
